// ==== hdl/tlas_core.sv ====
// Limit compare, sticky alarm and fault flags, alert pin and link-side register port
//
// Functional notes
// R1: Writable limit bank: 8-bit local high/low, 10-bit remote high/low over byte pairs.
// R2: Remote limit bits 9..2 in upper byte, bits 1..0 in lower byte bits 7..6.
// R3: Readings compared against zone limits drive flags and the selectable alert pin.
// R4: Limits and readings compared as plain unsigned binary temperatures.
// R5: Any limit violation sets its alarm flag (bits 3..6) and pulls alert low.
// R6: Remote: bit 3 when reading <= low limit, bit 4 when reading > high.
// R7: Local: bit 5 when reading <= low limit, bit 6 when reading > high.
// R8: Remote diode open sets alarm bit 2 and asserts alert.
// R9: Alarm bit 7 reads 1 while a conversion runs, else 0.
// R10: Reading alarm status clears only flags whose condition has gone.
// R11: Alert stays asserted until the host services the bus alert.
// R12: Writes to alarm status are ignored.
// R13: Fault bit 4 set when remote reading is out of its window.
// R14: Fault bit 5 set when local reading is out of its window.
// R15: Remote fault bit also set on diode open or short.
// R16: Several fault bits may be set together.
// R17: Fault bits hold until read, then clear only if the fault is gone.
// R18: Fault bit 7 reads 1 whenever any second-fault bit is set.
// R19: Second fault: bit 6 on diode open, bit 2 on fan stall, sticky.
// R20: Config bit 7 masks alarm conditions from asserting alert.
// R21: Shared pin is tach input unless config bit 5 selects alert.
// R22: Compare and update flags when each zone conversion completes.
// R23: Alert is open-drain, active low, released when not asserted.
`timescale 1ns/1ps
`include "tlas_defs.svh"

module tlas_core (
   // System clock domain
   input wire logic clk_sys,
   input wire logic rst_n,
   // Converter and fault inputs, same clock domain
   input wire logic [9:0] remote_temp,
   input wire tlas_pkg::tlas_byte_t local_temp,
   input wire logic remote_done,
   input wire logic local_done,
   input wire logic conv_busy,
   input wire logic diode_open,
   input wire logic diode_short,
   input wire logic fan_stall,
   // Shared alert/tach pin
   output logic alert_o,
   output logic alert_oe,
   output logic tach_sel,
   // Link clock domain register port
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic link_req,
   input wire logic link_wr,
   input wire tlas_pkg::tlas_byte_t link_addr,
   input wire tlas_pkg::tlas_byte_t link_wdata,
   input wire logic link_alert_svc,
   output tlas_pkg::tlas_byte_t link_rdata,
   output logic link_ack,
   output logic link_busy
);
   import tlas_pkg::*;

   // ----------------------------------------
   // Link side: request capture and toggles
   // ----------------------------------------
   tlas_byte_t lk_addr_q, lk_wdata_q, link_rdata_q;
   logic lk_wr_q, lk_req_tgl_q, lk_svc_tgl_q, link_busy_q, link_ack_q;
   logic lk_ack_s1_q, lk_ack_s2_q, lk_ack_s3_q;
   logic lk_ack_edge;
   // System-side answer, read here only once its toggle has crossed
   logic sy_ack_tgl_q;
   tlas_byte_t sy_rd_hold_q;

   assign lk_ack_edge = lk_ack_s2_q ^ lk_ack_s3_q;

   // Addr and data stay frozen while busy so the system side reads them safely
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         lk_addr_q <= 8'h00;
         lk_wdata_q <= 8'h00;
         lk_wr_q <= 1'b0;
         lk_req_tgl_q <= 1'b0;
      end else if (link_req && !link_busy_q) begin
         lk_addr_q <= link_addr;
         lk_wdata_q <= link_wdata;
         lk_wr_q <= link_wr;
         lk_req_tgl_q <= ~lk_req_tgl_q;
      end
   end

   // Busy from request until the answer returns
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         link_busy_q <= 1'b0;
      end else if (link_req && !link_busy_q) begin
         link_busy_q <= 1'b1;
      end else if (lk_ack_edge) begin
         link_busy_q <= 1'b0;
      end
   end

   // Alert service event from the host, sent as a toggle
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         lk_svc_tgl_q <= 1'b0;
      end else if (link_alert_svc) begin
         lk_svc_tgl_q <= ~lk_svc_tgl_q;
      end
   end

   // Answer toggle synchroniser and read data capture
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         lk_ack_s1_q <= 1'b0;
         lk_ack_s2_q <= 1'b0;
         lk_ack_s3_q <= 1'b0;
         link_ack_q <= 1'b0;
         link_rdata_q <= 8'h00;
      end else begin
         lk_ack_s1_q <= sy_ack_tgl_q;
         lk_ack_s2_q <= lk_ack_s1_q;
         lk_ack_s3_q <= lk_ack_s2_q;
         link_ack_q <= lk_ack_edge;
         if (lk_ack_edge) begin
            link_rdata_q <= sy_rd_hold_q;
         end
      end
   end

   assign link_rdata = link_rdata_q;
   assign link_ack = link_ack_q;
   assign link_busy = link_busy_q;

   // ----------------------------------------
   // System side: request and service sync
   // ----------------------------------------
   logic sy_req_s1_q, sy_req_s2_q, sy_req_s3_q;
   logic sy_svc_s1_q, sy_svc_s2_q, sy_svc_s3_q;
   logic acc, acc_rd, acc_wr, svc;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sy_req_s1_q <= 1'b0;
         sy_req_s2_q <= 1'b0;
         sy_req_s3_q <= 1'b0;
         sy_svc_s1_q <= 1'b0;
         sy_svc_s2_q <= 1'b0;
         sy_svc_s3_q <= 1'b0;
      end else begin
         sy_req_s1_q <= lk_req_tgl_q;
         sy_req_s2_q <= sy_req_s1_q;
         sy_req_s3_q <= sy_req_s2_q;
         sy_svc_s1_q <= lk_svc_tgl_q;
         sy_svc_s2_q <= sy_svc_s1_q;
         sy_svc_s3_q <= sy_svc_s2_q;
      end
   end

   assign acc = sy_req_s2_q ^ sy_req_s3_q;
   assign acc_rd = acc && !lk_wr_q;
   assign acc_wr = acc && lk_wr_q;
   assign svc = sy_svc_s2_q ^ sy_svc_s3_q;

   // ----------------------------------------
   // Limit bank and configuration
   // ----------------------------------------
   tlas_byte_t cfg_q, loc_hi_q, loc_lo_q, rem_hi_up_q, rem_lo_up_q;
   logic [1:0] rem_hi_dn_q, rem_lo_dn_q;
   tlas_remote_t rem_hi_lim, rem_lo_lim;

   // Lower limit bytes keep only their top two bits; the rest are don't-care
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_q <= `TLAS_RST_CONFIG;
         loc_hi_q <= `TLAS_RST_LOCAL_HIGH;
         loc_lo_q <= `TLAS_RST_LOCAL_LOW;
         rem_hi_up_q <= `TLAS_RST_REMOTE_UP;
         rem_lo_up_q <= `TLAS_RST_REMOTE_UP;
         rem_hi_dn_q <= `TLAS_RST_REMOTE_LO;
         rem_lo_dn_q <= `TLAS_RST_REMOTE_LO;
      end else if (acc_wr) begin
         unique case (lk_addr_q)
            `TLAS_OFS_CONFIG: cfg_q <= lk_wdata_q;
            `TLAS_OFS_LOCAL_HIGH: loc_hi_q <= lk_wdata_q; // R1
            `TLAS_OFS_LOCAL_LOW: loc_lo_q <= lk_wdata_q; // R1
            `TLAS_OFS_REMOTE_HIGH_UP: rem_hi_up_q <= lk_wdata_q; // R2
            `TLAS_OFS_REMOTE_LOW_UP: rem_lo_up_q <= lk_wdata_q; // R2
            `TLAS_OFS_REMOTE_HIGH_LO: rem_hi_dn_q <= lk_wdata_q[7:6]; // R2
            `TLAS_OFS_REMOTE_LOW_LO: rem_lo_dn_q <= lk_wdata_q[7:6]; // R2
            default: ; // Status registers and unmapped offsets ignore writes
         endcase
      end
   end

   assign rem_hi_lim = {rem_hi_up_q, rem_hi_dn_q}; // R2
   assign rem_lo_lim = {rem_lo_up_q, rem_lo_dn_q}; // R2

   // ----------------------------------------
   // Limit compare on conversion complete
   // ----------------------------------------
   logic rem_under_q, rem_over_q, loc_under_q, loc_over_q;

   // Unsigned compares; results hold until the zone's next conversion
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rem_under_q <= 1'b0;
         rem_over_q <= 1'b0;
         loc_under_q <= 1'b0;
         loc_over_q <= 1'b0;
      end else begin
         if (remote_done) begin // R22
            rem_under_q <= remote_temp <= rem_lo_lim; // R4 R6
            rem_over_q <= remote_temp > rem_hi_lim; // R4 R6
         end
         if (local_done) begin // R22
            loc_under_q <= local_temp <= loc_lo_q; // R4 R7
            loc_over_q <= local_temp > loc_hi_q; // R4 R7
         end
      end
   end

   // ----------------------------------------
   // Sticky flags, cleared by read if gone
   // ----------------------------------------
   logic [6:2] stat_cond, stat_q;
   logic [5:4] f1_cond, f1_q;
   logic [6:2] f2_cond, f2_q;
   logic rd_stat, rd_f1, rd_f2;

   assign stat_cond = {loc_over_q, loc_under_q, rem_over_q, rem_under_q, diode_open}; // R3 R5 R8
   assign f1_cond[`TLAS_F1_LOCAL] = loc_over_q | loc_under_q; // R14
   assign f1_cond[`TLAS_F1_REMOTE] = rem_over_q | rem_under_q | diode_open | diode_short; // R13 R15
   assign f2_cond = {diode_open, 3'b000, fan_stall}; // R19
   assign rd_stat = acc_rd && (lk_addr_q == `TLAS_OFS_ALARM_STATUS);
   assign rd_f1 = acc_rd && (lk_addr_q == `TLAS_OFS_FAULT_FIRST);
   assign rd_f2 = acc_rd && (lk_addr_q == `TLAS_OFS_FAULT_SECOND);

   // A condition present in the clearing cycle keeps its flag set
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stat_q <= 5'h00;
      end else begin
         stat_q <= stat_cond | (stat_q & ~{5{rd_stat}}); // R10 R12
      end
   end

   // Independent bits, so several faults can show in one read
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         f1_q <= 2'h0;
         f2_q <= 5'h00;
      end else begin
         f1_q <= f1_cond | (f1_q & ~{2{rd_f1}}); // R16 R17
         f2_q <= f2_cond | (f2_q & ~{5{rd_f2}}); // R19
      end
   end

   // ----------------------------------------
   // Read mux and answer toggle
   // ----------------------------------------
   tlas_byte_t rd_data;

   always_comb begin
      rd_data = 8'h00;
      unique case (lk_addr_q)
         `TLAS_OFS_ALARM_STATUS: rd_data = {conv_busy, stat_q, 2'b00}; // R9
         `TLAS_OFS_CONFIG: rd_data = cfg_q;
         `TLAS_OFS_LOCAL_HIGH: rd_data = loc_hi_q;
         `TLAS_OFS_LOCAL_LOW: rd_data = loc_lo_q;
         `TLAS_OFS_REMOTE_HIGH_UP: rd_data = rem_hi_up_q;
         `TLAS_OFS_REMOTE_LOW_UP: rd_data = rem_lo_up_q;
         `TLAS_OFS_REMOTE_HIGH_LO: rd_data = {rem_hi_dn_q, 6'h00};
         `TLAS_OFS_REMOTE_LOW_LO: rd_data = {rem_lo_dn_q, 6'h00};
         `TLAS_OFS_FAULT_FIRST: rd_data = {|f2_q, 1'b0, f1_q, 4'h0}; // R18
         `TLAS_OFS_FAULT_SECOND: rd_data = {1'b0, f2_q[6], 3'b000, f2_q[2], 2'b00};
         default: rd_data = 8'h00;
      endcase
   end

   // Hold register is stable long before the link side sees the toggle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sy_rd_hold_q <= 8'h00;
         sy_ack_tgl_q <= 1'b0;
      end else if (acc) begin
         sy_rd_hold_q <= lk_wr_q ? 8'h00 : rd_data;
         sy_ack_tgl_q <= ~sy_ack_tgl_q;
      end
   end

   // ----------------------------------------
   // Alert latch and shared pin
   // ----------------------------------------
   logic alert_q, alert_oe_q, tach_sel_q, alarm_any, alert_sel;

   assign alert_sel = cfg_q[`TLAS_CFG_ALERT_SEL];
   assign alarm_any = (|stat_cond) && !cfg_q[`TLAS_CFG_ALERT_MASK]; // R5 R8 R20

   // Latch outlives the flags; host service or clearing the alert select releases it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= alert_sel && (alarm_any || (alert_q && !svc)); // R11 R21
      end
   end

   // Open-drain drive: output low, enable only while asserted
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         alert_oe_q <= 1'b0;
         tach_sel_q <= 1'b1;
      end else begin
         alert_oe_q <= alert_sel && (alarm_any || (alert_q && !svc)); // R23
         tach_sel_q <= !alert_sel; // R21
      end
   end

   assign alert_o = 1'b0; // R23
   assign alert_oe = alert_oe_q;
   assign tach_sel = tach_sel_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence seq_rem_low_hit;
      remote_done && (remote_temp <= rem_lo_lim);
   endsequence

   sequence seq_rem_high_hit;
      remote_done && (remote_temp > rem_hi_lim);
   endsequence

   chk_remote_under_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
      seq_rem_low_hit |=> rem_under_q ##1 stat_q[`TLAS_ST_REMOTE_UNDER])
      else $error("remote under flag missing");

   chk_remote_over_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
      seq_rem_high_hit |=> ##1 stat_q[`TLAS_ST_REMOTE_OVER] && f1_q[`TLAS_F1_REMOTE])
      else $error("remote over flag missing");

   chk_local_limit_flags: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
      local_done && (local_temp > loc_hi_q) |=> ##1 stat_q[`TLAS_ST_LOCAL_OVER] && f1_q[`TLAS_F1_LOCAL])
      else $error("local over flag missing");

   chk_diode_open_flags: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
      diode_open |=> stat_q[`TLAS_ST_DIODE_OPEN] && f2_q[`TLAS_F2_DIODE] && f1_q[`TLAS_F1_REMOTE])
      else $error("diode open flags missing");

   chk_busy_read_bit: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
      rd_stat |=> sy_rd_hold_q[`TLAS_ST_BUSY] == $past(conv_busy))
      else $error("busy bit wrong on read");

   chk_flag_sticky_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
      f1_q[`TLAS_F1_LOCAL] && !rd_f1 |=> f1_q[`TLAS_F1_LOCAL])
      else $error("fault bit dropped without read");

   chk_read_clears_gone: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
      rd_stat && !loc_over_q && $stable(loc_over_q) ##0 !local_done |=> !stat_q[`TLAS_ST_LOCAL_OVER])
      else $error("stale flag survived read");

   chk_status_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
      acc_wr && (lk_addr_q == `TLAS_OFS_ALARM_STATUS) && stat_q[`TLAS_ST_DIODE_OPEN]
      |=> stat_q[`TLAS_ST_DIODE_OPEN])
      else $error("status write changed flags");

   chk_alert_hold_service: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
      alert_q && alert_sel && !svc |=> alert_q && alert_oe)
      else $error("alert released without service");

   chk_alert_mask_block: assert property (@(posedge clk_sys) disable iff (!rst_n) // R20
      !alert_q && cfg_q[`TLAS_CFG_ALERT_MASK] |=> !alert_q)
      else $error("masked alarm asserted alert");

   chk_pin_default_tach: assert property (@(posedge clk_sys) disable iff (!rst_n) // R21
      !alert_sel |=> !alert_oe && tach_sel)
      else $error("pin driven while tach selected");

   chk_summary_bit: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
      rd_f1 && (|f2_q) |=> sy_rd_hold_q[`TLAS_F1_SUMMARY])
      else $error("summary bit missing");

   chk_link_answer_time: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      link_req && !link_busy |=> link_busy ##[1:12] link_ack)
      else $error("link answer late");

endmodule

// ==== hdl/tlas_defs.svh ====
// Register offsets, field positions and reset values for the alert status block
`ifndef TLAS_DEFS_SVH
`define TLAS_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TLAS_OFS_ALARM_STATUS 8'h02
`define TLAS_OFS_CONFIG 8'h09
`define TLAS_OFS_LOCAL_HIGH 8'h0b
`define TLAS_OFS_LOCAL_LOW 8'h0c
`define TLAS_OFS_REMOTE_HIGH_UP 8'h0d
`define TLAS_OFS_REMOTE_LOW_UP 8'h0e
`define TLAS_OFS_REMOTE_HIGH_LO 8'h13
`define TLAS_OFS_REMOTE_LOW_LO 8'h14
`define TLAS_OFS_FAULT_FIRST 8'h41
`define TLAS_OFS_FAULT_SECOND 8'h42

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TLAS_RST_CONFIG 8'h00
`define TLAS_RST_LOCAL_HIGH 8'h55
`define TLAS_RST_LOCAL_LOW 8'h00
`define TLAS_RST_REMOTE_UP 8'h55
`define TLAS_RST_REMOTE_LO 2'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TLAS_CFG_ALERT_MASK 7
`define TLAS_CFG_ALERT_SEL 5
`define TLAS_ST_BUSY 7
`define TLAS_ST_LOCAL_OVER 6
`define TLAS_ST_LOCAL_UNDER 5
`define TLAS_ST_REMOTE_OVER 4
`define TLAS_ST_REMOTE_UNDER 3
`define TLAS_ST_DIODE_OPEN 2
`define TLAS_F1_SUMMARY 7
`define TLAS_F1_LOCAL 5
`define TLAS_F1_REMOTE 4
`define TLAS_F2_DIODE 6
`define TLAS_F2_FAN 2

`endif

// ==== hdl/tlas_pkg.sv ====
// Types shared by the alert status block
package tlas_pkg;
   typedef logic [7:0] tlas_byte_t;
   typedef logic [9:0] tlas_remote_t;
endpackage

// ==== sim/test_temp_limit_alert_status.sv ====
// Self-checking bench for the alert status block
`timescale 1ns/1ps

module test_temp_limit_alert_status;
   import tlas_pkg::*;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk_sys, rst_n, link_clk, link_rst_n;
   logic [9:0] remote_temp;
   tlas_byte_t local_temp, link_addr, link_wdata, link_rdata;
   logic remote_done, local_done, conv_busy, diode_open, diode_short, fan_stall;
   logic alert_o, alert_oe, tach_sel, alert_pin;
   logic link_req, link_wr, link_alert_svc, link_ack, link_busy;
   int n_mismatch = 0;
   int num_checks = 0;

   // Pin level with its pull-up
   assign alert_pin = alert_oe ? alert_o : 1'b1;

   tlas_core i_tlas_core (
      .clk_sys(clk_sys), .rst_n(rst_n), .remote_temp(remote_temp), .local_temp(local_temp),
      .remote_done(remote_done), .local_done(local_done), .conv_busy(conv_busy), .diode_open(diode_open),
      .diode_short(diode_short), .fan_stall(fan_stall), .alert_o(alert_o), .alert_oe(alert_oe),
      .tach_sel(tach_sel), .link_clk(link_clk), .link_rst_n(link_rst_n), .link_req(link_req),
      .link_wr(link_wr), .link_addr(link_addr), .link_wdata(link_wdata), .link_alert_svc(link_alert_svc),
      .link_rdata(link_rdata), .link_ack(link_ack), .link_busy(link_busy)
   );

   tlas_host_model i_tlas_host_model (
      .link_clk(link_clk), .link_req(link_req), .link_wr(link_wr), .link_addr(link_addr),
      .link_wdata(link_wdata), .link_alert_svc(link_alert_svc), .link_rdata(link_rdata),
      .link_ack(link_ack), .link_busy(link_busy)
   );

   // ----------------------------------------
   // Clocks and watchdog
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Link clock offset so its edges never line up with the system clock
   initial begin
      link_clk = 1'b0;
      #7;
      forever #40 link_clk = ~link_clk;
   end
   // About 80 accesses of under 1.5 us each
   initial begin
      #400000;
      n_mismatch++;
      end_of_test();
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input tlas_byte_t a, input tlas_byte_t exp);
      tlas_byte_t d;
      i_tlas_host_model.access(1'b0, a, 8'h00, d);
      check($sformatf("register %h", a), d, exp);
   endtask
   task automatic wr(input tlas_byte_t a, input tlas_byte_t v);
      tlas_byte_t d;
      i_tlas_host_model.access(1'b1, a, v, d);
   endtask
   task automatic pin(input logic exp);
      check("alert pin", {7'h00, alert_pin}, {7'h00, exp});
   endtask
   task automatic drive(ref logic s, input logic v);
      @(negedge clk_sys);
      s = v;
      repeat (4) @(negedge clk_sys);
   endtask
   // Both zones finish together; flags settle two edges later
   task automatic conv(input logic [9:0] r, input tlas_byte_t l);
      @(negedge clk_sys);
      remote_temp = r;
      local_temp = l;
      remote_done = 1'b1;
      local_done = 1'b1;
      @(negedge clk_sys);
      remote_done = 1'b0;
      local_done = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Reset values, then write all places and read back; remote high 131, low 35
   task automatic t_regs();
      tlas_byte_t ad[11] = '{8'h02, 8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h13, 8'h14, 8'h41, 8'h42, 8'h50};
      tlas_byte_t rv[11] = '{8'h00, 8'h00, 8'h55, 8'h00, 8'h55, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      tlas_byte_t wv[11] = '{8'hff, 8'h1f, 8'h40, 8'h10, 8'h20, 8'h08, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
      tlas_byte_t av[11] = '{8'h00, 8'h1f, 8'h40, 8'h10, 8'h20, 8'h08, 8'hc0, 8'hc0, 8'h00, 8'h00, 8'h00};
      check("tach select", {7'h00, tach_sel}, 8'h01);
      pin(1'b1);
      for (int i = 0; i < 11; i++) rd(ad[i], rv[i]);
      for (int i = 0; i < 11; i++) wr(ad[i], wv[i]);
      for (int i = 0; i < 11; i++) rd(ad[i], av[i]);
   endtask
   task automatic t_remote();
      conv(10'd131, 8'h20);
      rd(8'h02, 8'h00);
      conv(10'd132, 8'h20);
      rd(8'h02, 8'h10);
      rd(8'h41, 8'h10);
      conv(10'd35, 8'h20);
      rd(8'h02, 8'h18);
      rd(8'h02, 8'h08);
      conv(10'd36, 8'h20);
      rd(8'h02, 8'h08);
      rd(8'h02, 8'h00);
      rd(8'h41, 8'h10);
      rd(8'h41, 8'h00);
   endtask
   task automatic t_local();
      conv(10'd36, 8'h40);
      rd(8'h02, 8'h00);
      conv(10'd132, 8'h41);
      rd(8'h02, 8'h50);
      rd(8'h41, 8'h30);
      conv(10'd36, 8'h10);
      rd(8'h02, 8'h70);
      rd(8'h02, 8'h20);
      rd(8'h41, 8'h30);
      rd(8'h41, 8'h20);
      conv(10'd36, 8'h20);
      rd(8'h02, 8'h20);
      rd(8'h02, 8'h00);
      rd(8'h41, 8'h20);
      rd(8'h41, 8'h00);
   endtask
   task automatic t_diode();
      drive(diode_open, 1'b1);
      rd(8'h02, 8'h04);
      rd(8'h41, 8'h90);
      rd(8'h42, 8'h40);
      drive(diode_open, 1'b0);
      // Writes while the flags are only sticky must leave them alone
      wr(8'h02, 8'h00);
      wr(8'h41, 8'h00);
      wr(8'h42, 8'h00);
      rd(8'h02, 8'h04);
      rd(8'h02, 8'h00);
      rd(8'h42, 8'h40);
      rd(8'h41, 8'h10);
      rd(8'h41, 8'h00);
      drive(fan_stall, 1'b1);
      rd(8'h42, 8'h04);
      rd(8'h41, 8'h80);
      drive(fan_stall, 1'b0);
      rd(8'h42, 8'h04);
      rd(8'h41, 8'h00);
      drive(diode_short, 1'b1);
      rd(8'h41, 8'h10);
      rd(8'h42, 8'h00);
      drive(diode_short, 1'b0);
      rd(8'h41, 8'h10);
      rd(8'h41, 8'h00);
      drive(conv_busy, 1'b1);
      rd(8'h02, 8'h80);
      drive(conv_busy, 1'b0);
      rd(8'h02, 8'h00);
   endtask
   // Alert outlives its flags until serviced; mask and deselect keep the pin released
   task automatic t_alert();
      wr(8'h09, 8'h20);
      repeat (4) @(negedge clk_sys);
      check("tach select", {7'h00, tach_sel}, 8'h00);
      pin(1'b1);
      conv(10'd132, 8'h20);
      pin(1'b0);
      conv(10'd36, 8'h20);
      rd(8'h02, 8'h10);
      rd(8'h02, 8'h00);
      pin(1'b0);
      i_tlas_host_model.service();
      repeat (8) @(negedge clk_sys);
      pin(1'b1);
      wr(8'h09, 8'ha0);
      conv(10'd132, 8'h20);
      pin(1'b1);
      wr(8'h09, 8'h20);
      repeat (4) @(negedge clk_sys);
      pin(1'b0);
      wr(8'h09, 8'h00);
      repeat (4) @(negedge clk_sys);
      pin(1'b1);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      link_rst_n = 1'b0;
      remote_temp = 10'h000;
      local_temp = 8'h00;
      remote_done = 1'b0;
      local_done = 1'b0;
      conv_busy = 1'b0;
      diode_open = 1'b0;
      diode_short = 1'b0;
      fan_stall = 1'b0;
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (2) @(negedge link_clk);
      link_rst_n = 1'b1;
      repeat (4) @(posedge link_clk);
      t_regs();
      t_remote();
      t_local();
      t_diode();
      t_alert();
      end_of_test();
   end
endmodule

// ==== sim/tlas_host_model.sv ====
// Host model on the link register port of the alert status block
`timescale 1ns/1ps

module tlas_host_model (
   // Link clock
   input wire logic link_clk,
   // Request and service
   output logic link_req,
   output logic link_wr,
   output tlas_pkg::tlas_byte_t link_addr,
   output tlas_pkg::tlas_byte_t link_wdata,
   output logic link_alert_svc,
   // Answer
   input wire tlas_pkg::tlas_byte_t link_rdata,
   input wire logic link_ack,
   input wire logic link_busy
);
   import tlas_pkg::*;

   // ----------------------------------------
   // Idle levels
   // ----------------------------------------
   initial begin
      link_req = 1'b0;
      link_wr = 1'b0;
      link_addr = 8'h00;
      link_wdata = 8'h00;
      link_alert_svc = 1'b0;
   end

   // ----------------------------------------
   // Transfers
   // ----------------------------------------
   // Request stands for one taking edge only; held on, it is taken again only once busy drops
   task automatic access(input logic wr, input tlas_byte_t a, input tlas_byte_t wd, output tlas_byte_t rdat);
      int n;
      n = 0;
      rdat = 8'hxx;
      @(negedge link_clk);
      link_req = 1'b1;
      link_wr = wr;
      link_addr = a;
      link_wdata = wd;
      do @(posedge link_clk); while (link_busy !== 1'b0);
      @(negedge link_clk);
      link_req = 1'b0;
      // Released lines flip, so a stale copy never passes for live data
      link_wr = ~wr;
      link_addr = ~a;
      link_wdata = ~wd;
      do begin
         @(posedge link_clk);
         n++;
      end while (link_ack !== 1'b1 && n < 20);
      if (link_ack === 1'b1) rdat = link_rdata;
   endtask

   // Service pulse covers exactly one rising edge
   task automatic service();
      @(negedge link_clk);
      link_alert_svc = 1'b1;
      @(negedge link_clk);
      link_alert_svc = 1'b0;
   endtask
endmodule
